// >>> src/pbio_pkg.sv
// Constants and types for the port B I/O and interrupt control block
package pbio_pkg;
  localparam logic [7:0] PBIO_ADDR_PORT   = 8'h06;
  localparam logic [7:0] PBIO_ADDR_PWR    = 8'h08;
  localparam logic [7:0] PBIO_ADDR_WAKE   = 8'h09;
  localparam logic [7:0] PBIO_ADDR_PDN    = 8'h0B;
  localparam logic [7:0] PBIO_ADDR_ODR    = 8'h0C;
  localparam logic [7:0] PBIO_ADDR_PUP    = 8'h0D;
  localparam logic [7:0] PBIO_ADDR_IEN    = 8'h0E;
  localparam logic [7:0] PBIO_ADDR_IFLG   = 8'h0F;

  localparam logic [7:0] PBIO_RST_DIR     = 8'hFF;
  localparam logic [7:0] PBIO_RST_CFG     = 8'hBF;
  localparam logic [7:0] PBIO_RST_PWR     = 8'hFF;
  localparam logic [7:0] PBIO_RST_PULL    = 8'hFF;
  localparam logic [7:0] PBIO_RST_ZERO    = 8'h00;
  localparam logic [7:0] PBIO_PWR_ONES    = 8'h1F;
  localparam logic [7:0] PBIO_IEN_ONES    = 8'h78;
  localparam logic [7:0] PBIO_IFLG_MASK   = 8'h07;
  localparam logic [7:0] PBIO_PDN_CTRL    = 8'h70;
  localparam logic [7:0] PBIO_PIN_MASK    = 8'hF7;

  localparam int PBIO_PWR_WDT  = 7;
  localparam int PBIO_PWR_EIS  = 6;
  localparam int PBIO_PWR_LVD  = 5;
  localparam int PBIO_PDN_LSB  = 4;
  localparam int PBIO_IEN_TMR  = 0;
  localparam int PBIO_IEN_CHG  = 1;
  localparam int PBIO_IEN_EXT  = 2;
  localparam int PBIO_IEN_GIE  = 7;
  localparam int PBIO_CFG_EDG  = 6;
  localparam int PBIO_CFG_TCS  = 5;
  localparam int PBIO_CFG_TSE  = 4;
  localparam int PBIO_CFG_PSA  = 3;
  localparam int PBIO_PIN_INP  = 3;
  localparam int PBIO_PIN_TCK  = 2;

  localparam logic [9:0] PBIO_IRQ_VECTOR = 10'h008;

  typedef enum logic [1:0] {
    PBIO_WAKE_NONE   = 2'b00,
    PBIO_WAKE_RESUME = 2'b01,
    PBIO_WAKE_VECTOR = 2'b10
  } pbio_wake_t;
endpackage

// >>> src/pbio_pin_if.sv
// Bundle of per-pin control signals between the control and pad logic
`timescale 1ns/1ps
interface pbio_pin_if;
  logic [7:0] latch;
  logic [7:0] dir;
  logic [7:0] odr;
  logic [7:0] pup_n;
  logic [7:0] pdn_n;
  logic       force_t2;
  logic [7:0] pin_oe;
  logic [7:0] pin_out;
  logic [7:0] pup_on;
  logic [7:0] pdn_on;
  modport ctrl (output latch, dir, odr, pup_n, pdn_n, force_t2, input pin_oe, pin_out, pup_on, pdn_on);
  modport pad  (input latch, dir, odr, pup_n, pdn_n, force_t2, output pin_oe, pin_out, pup_on, pdn_on);
endinterface

// >>> src/pbio_pad_ctrl.sv
// Pin driver and weak pull control for the eight port pins
`timescale 1ns/1ps
module pbio_pad_ctrl
  import pbio_pkg::*;
(
  pbio_pin_if.pad p
);
  logic [7:0] is_out;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      if (g == PBIO_PIN_INP) begin : g_inp
        assign is_out[g] = 1'b0;
      end else if (g == PBIO_PIN_TCK) begin : g_tck
        assign is_out[g] = ~p.dir[g] & ~p.force_t2;
      end else begin : g_io
        assign is_out[g] = ~p.dir[g];
      end
      // Open drain only pulls low; a high latch releases the pin
      assign p.pin_out[g] = p.latch[g];
      assign p.pin_oe[g]  = is_out[g] & ~(p.odr[g] & p.latch[g]);
      assign p.pup_on[g]  = ~p.pup_n[g] & ~is_out[g];
      assign p.pdn_on[g]  = ~p.pdn_n[g] & ~is_out[g];
    end
  endgenerate
endmodule

// >>> src/pbio_edge_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pbio_edge_sync (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Pins
  input  wire logic [7:0] async_i,
  output logic      [7:0] sync_o
);
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [7:0] s3_r;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // A bit moves only once the two later stages agree
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_o <= 8'h00;
    end else begin
      sync_o <= (s2_r & s3_r) | (sync_o & (s2_r | s3_r));
    end
  end
endmodule

// >>> src/pbio_top.sv
// Port B control: registers, pin control and interrupt flags
`timescale 1ns/1ps
module pbio_top
  import pbio_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Register file access from the core
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Instruction strobes; the two load strobes carry the accumulator
  input  wire logic [7:0] acc_i,
  input  wire logic       dir_load_i,
  input  wire logic       cfg_load_i,
  input  wire logic       return_from_irq_instr_i,
  // Core events
  input  wire logic       timer_ovf_i,
  input  wire logic       sleeping_i,
  input  wire logic [7:0] alt_func_i,
  // Pins
  input  wire logic [7:0] pin_i,
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe_o,
  output logic      [7:0] pull_up_o,
  output logic      [7:0] pull_down_o,
  // Controls to other blocks
  output logic            watchdog_enable_o,
  output logic            low_voltage_detect_enable_o,
  output logic            timer_clock_source_o,
  output logic            timer_source_edge_o,
  output logic            prescaler_assign_o,
  output logic      [7:0] timer_div_o,
  output logic      [7:0] watchdog_div_o,
  // Interrupt to the core
  output logic            irq_take_o,
  output logic            wake_o,
  output pbio_pkg::pbio_wake_t wake_kind_o,
  output logic      [9:0] irq_vector_o
);
  import pbio_pkg::*;

  logic [7:0] latch_r;
  logic [7:0] dir_r;
  logic [7:0] cfg_r;
  logic [7:0] pwr_r;
  logic [7:0] wake_en_r;
  logic [7:0] pdn_r;
  logic [7:0] odr_r;
  logic [7:0] pup_r;
  logic [7:0] ien_r;
  logic [2:0] flag_r;
  logic [7:0] ref_r;
  logic       ext_prev_r;
  logic [7:0] pins_s;
  logic [7:0] rd_nxt;
  logic       ext_lvl;
  logic       ext_edge;
  logic       chg_evt;
  logic [7:0] chg_mask;
  logic [2:0] evt;
  logic       port_acc;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic en);
    return en && (a == off);
  endfunction

  pbio_pin_if pif();

  pbio_edge_sync pbio_edge_sync_inst (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (pin_i),
    .sync_o    (pins_s)
  );

  pbio_pad_ctrl pbio_pad_ctrl_inst (
    .p (pif)
  );

  assign pif.latch    = latch_r;
  assign pif.dir      = dir_r;
  assign pif.odr      = odr_r;
  assign pif.pup_n    = {pup_r[7:4], 1'b1, pup_r[2:0]};
  assign pif.pdn_n    = {5'h1F, pdn_r[6:4]};
  assign pif.force_t2 = cfg_r[PBIO_CFG_TCS];
  assign pin_o        = pif.pin_out;
  assign pin_oe_o     = pif.pin_oe;
  assign pull_up_o    = pif.pup_on;
  assign pull_down_o  = pif.pdn_on;

  assign port_acc = hit(reg_addr_i, PBIO_ADDR_PORT, reg_wr_i | reg_rd_i);

  // Output latch; pin three has none that drives
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      latch_r <= PBIO_RST_ZERO;
    end else if (hit(reg_addr_i, PBIO_ADDR_PORT, reg_wr_i)) begin
      latch_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dir_r <= PBIO_RST_DIR;
    end else if (dir_load_i) begin
      dir_r <= acc_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_r <= PBIO_RST_CFG;
    end else if (cfg_load_i) begin
      cfg_r <= acc_i;
    end
  end

  // Control registers written over the register file
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pwr_r     <= PBIO_RST_PWR;
      wake_en_r <= PBIO_RST_ZERO;
      pdn_r     <= PBIO_RST_PULL;
      odr_r     <= PBIO_RST_ZERO;
      pup_r     <= PBIO_RST_PULL;
    end else if (reg_wr_i) begin
      if (reg_addr_i == PBIO_ADDR_PWR) begin
        pwr_r <= reg_wdata_i | PBIO_PWR_ONES;
      end
      if (reg_addr_i == PBIO_ADDR_WAKE) begin
        wake_en_r <= reg_wdata_i;
      end
      if (reg_addr_i == PBIO_ADDR_PDN) begin
        pdn_r <= reg_wdata_i;
      end
      if (reg_addr_i == PBIO_ADDR_ODR) begin
        odr_r <= reg_wdata_i;
      end
      if (reg_addr_i == PBIO_ADDR_PUP) begin
        pup_r <= reg_wdata_i;
      end
    end
  end

  assign watchdog_enable_o           = pwr_r[PBIO_PWR_WDT];
  assign low_voltage_detect_enable_o = pwr_r[PBIO_PWR_LVD];
  assign timer_clock_source_o        = cfg_r[PBIO_CFG_TCS];
  assign timer_source_edge_o         = cfg_r[PBIO_CFG_TSE];
  assign prescaler_assign_o          = cfg_r[PBIO_CFG_PSA];
  // Divisions encoded as log2 of the ratio
  assign timer_div_o    = {5'h00, cfg_r[2:0]} + 8'h01;
  assign watchdog_div_o = {5'h00, cfg_r[2:0]};

  // External pin edge detect, only while the select bit routes pin zero
  assign ext_lvl  = pins_s[0];
  assign ext_edge = pwr_r[PBIO_PWR_EIS] &
                    (cfg_r[PBIO_CFG_EDG] ? (ext_lvl & ~ext_prev_r) : (~ext_lvl & ext_prev_r));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_lvl;
    end
  end

  // Change detect over enabled input pins, excluding pin zero in interrupt mode
  assign chg_mask = wake_en_r & dir_r & {7'h7F, ~pwr_r[PBIO_PWR_EIS]};
  assign chg_evt  = ien_r[PBIO_IEN_CHG] & |((pins_s ^ ref_r) & chg_mask);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ref_r <= PBIO_RST_ZERO;
    end else if (port_acc) begin
      ref_r <= pins_s;
    end
  end

  assign evt = {ext_edge, chg_evt, timer_ovf_i};

  // Events win over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag_r <= 3'b000;
    end else if (hit(reg_addr_i, PBIO_ADDR_IFLG, reg_wr_i)) begin
      flag_r <= (flag_r & reg_wdata_i[2:0]) | evt;
    end else begin
      flag_r <= flag_r | evt;
    end
  end

  assign irq_take_o = ien_r[PBIO_IEN_GIE] & |(flag_r & ien_r[2:0]);
  assign wake_o     = sleeping_i & |(flag_r & ien_r[2:0]);
  assign irq_vector_o = PBIO_IRQ_VECTOR;

  always_comb begin
    if (!wake_o) begin
      wake_kind_o = PBIO_WAKE_NONE;
    end else if (ien_r[PBIO_IEN_GIE]) begin
      wake_kind_o = PBIO_WAKE_VECTOR;
    end else begin
      wake_kind_o = PBIO_WAKE_RESUME;
    end
  end

  // Hardware clears global enable on take; return sets it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ien_r <= PBIO_IEN_ONES;
    end else begin
      if (hit(reg_addr_i, PBIO_ADDR_IEN, reg_wr_i)) begin
        ien_r <= reg_wdata_i | PBIO_IEN_ONES;
      end
      if (irq_take_o) begin
        ien_r[PBIO_IEN_GIE] <= 1'b0;
      end else if (return_from_irq_instr_i) begin
        ien_r[PBIO_IEN_GIE] <= 1'b1;
      end
    end
  end

  always_comb begin
    case (reg_addr_i)
      PBIO_ADDR_PORT: rd_nxt = pins_s & ~alt_func_i;
      PBIO_ADDR_PWR:  rd_nxt = pwr_r | PBIO_PWR_ONES;
      PBIO_ADDR_WAKE: rd_nxt = wake_en_r;
      PBIO_ADDR_PDN:  rd_nxt = pdn_r;
      PBIO_ADDR_ODR:  rd_nxt = odr_r;
      PBIO_ADDR_PUP:  rd_nxt = pup_r;
      PBIO_ADDR_IEN:  rd_nxt = ien_r | PBIO_IEN_ONES;
      PBIO_ADDR_IFLG: rd_nxt = {5'h00, flag_r & ien_r[2:0]};
      default:        rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end
  end
endmodule

// >>> bench/pbio_pins.sv
// Board-side model of the eight port pins
`timescale 1ns/1ps
module pbio_pins (
  // Clock
  input  wire logic       clk_i,
  // Pad controls from the block
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] pu_i,
  input  wire logic [7:0] pd_i,
  // Board drivers set by the bench
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_v_i,
  // Resolved levels
  output logic      [7:0] pin_o
);
  logic [7:0] flt_r = 8'h55;
  // Undriven pins wander so a stale level never passes for a driven one
  always_ff @(posedge clk_i) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_v_i[i] : pu_i[i] ? 1'b1 : pd_i[i] ? 1'b0 : flt_r[i];
    end
  end
endmodule

// >>> bench/pbio_props.sv
// Port-level assertions for the port B control block
`timescale 1ns/1ps
module pbio_props
  import pbio_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] acc_i,
  input wire logic       dir_load_i,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pull_up_o,
  input wire logic [7:0] pull_down_o,
  input wire logic       timer_clock_source_o,
  input wire logic [7:0] timer_div_o,
  input wire logic [7:0] watchdog_div_o,
  input wire logic       irq_take_o,
  input wire logic       watchdog_enable_o,
  input wire logic       low_voltage_detect_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_in_only; !pin_oe_o[PBIO_PIN_INP]; endproperty
  a_in_only: assert property (p_in_only) else $error("pin three driven");
  property p_pull_off; ((pull_up_o | pull_down_o) & pin_oe_o) == 8'h00 && pull_down_o[7:3] == 5'h00; endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull on driven pin");
  property p_tck_in; timer_clock_source_o |-> !pin_oe_o[PBIO_PIN_TCK]; endproperty
  a_tck_in: assert property (p_tck_in) else $error("pin two driven");
  property p_div; timer_div_o == watchdog_div_o + 8'h01 && watchdog_div_o < 8'h08; endproperty
  a_div: assert property (p_div) else $error("divider mismatch");
  property p_take_once; irq_take_o |=> !irq_take_o; endproperty
  a_take_once: assert property (p_take_once) else $error("global enable kept");
  property p_pwr_ctl; reg_wr_i && reg_addr_i == PBIO_ADDR_PWR
    |=> {watchdog_enable_o, low_voltage_detect_enable_o} == {$past(reg_wdata_i[7]), $past(reg_wdata_i[5])}; endproperty
  a_pwr_ctl: assert property (p_pwr_ctl) else $error("power enables");
  property p_ien_rd; reg_rd_i && reg_addr_i == PBIO_ADDR_IEN |=> reg_rdata_o[6:3] == 4'hF; endproperty
  a_ien_rd: assert property (p_ien_rd) else $error("enable ones");
  property p_flg_rd; reg_rd_i && reg_addr_i == PBIO_ADDR_IFLG |=> reg_rdata_o[7:3] == 5'h00; endproperty
  a_flg_rd: assert property (p_flg_rd) else $error("flag zeros");
  property p_dir_in; dir_load_i && acc_i == 8'hFF |=> pin_oe_o == 8'h00 [*2]; endproperty
  a_dir_in: assert property (p_dir_in) else $error("inputs driven");
endmodule
bind pbio_top pbio_props pbio_props_inst (.*);

// >>> bench/port_b_io_and_interrupt_control_tb_top.sv
// Self-checking bench for the port B control block
`timescale 1ns/1ps
module port_b_io_and_interrupt_control_tb_top;
  import pbio_pkg::*;
  logic       clk_i, sys_rst_i, reg_wr_i, reg_rd_i, dir_load_i, cfg_load_i, return_from_irq_instr_i, timer_ovf_i, sleeping_i;
  logic [7:0] reg_addr_i, reg_wdata_i, acc_i, alt_func_i, pin_i, ext_en, ext_v, reg_rdata_o, pin_o, pin_oe_o;
  logic [7:0] pull_up_o, pull_down_o, timer_div_o, watchdog_div_o;
  logic       watchdog_enable_o, low_voltage_detect_enable_o, timer_clock_source_o;
  logic       timer_source_edge_o, prescaler_assign_o, irq_take_o, wake_o;
  pbio_wake_t wake_kind_o;
  logic [9:0] irq_vector_o;
  int         n_errors, cmp_count, cyc;
  pbio_top pbio_top_inst (.*);
  pbio_pins pbio_pins_inst (.clk_i(clk_i), .oe_i(pin_oe_o), .out_i(pin_o), .pu_i(pull_up_o),
    .pd_i(pull_down_o), .ext_en_i(ext_en), .ext_v_i(ext_v), .pin_o(pin_i));
  task automatic give_verdict();
    $display("Compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, reg_rdata_o);
  endtask
  // Loads direction (cfg 0) or timer configuration (cfg 1) from the accumulator
  task automatic ld(input bit cfg, input logic [7:0] v);
    @(posedge clk_i);
    acc_i <= v;
    if (cfg) cfg_load_i <= 1'b1;
    else dir_load_i <= 1'b1;
    @(posedge clk_i);
    cfg_load_i <= 1'b0;
    dir_load_i <= 1'b0;
    #1;
  endtask
  task automatic ovf();
    @(posedge clk_i);
    timer_ovf_i <= 1'b1;
    @(posedge clk_i);
    timer_ovf_i <= 1'b0;
    #1;
  endtask
  // Pins pass a synchroniser, so allow settling before reading them
  task automatic pins(input logic [7:0] v);
    ext_v <= v;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic t_reset();
    logic [7:0] ad [8] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
    logic [7:0] ex [8] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h78, 8'h00};
    chk("cfg", {4'h8, 3'h7, 1'b1, 1'b1, 1'b0}, {timer_div_o[3:0], watchdog_div_o[2:0],
      timer_source_edge_o, prescaler_assign_o, pin_oe_o[2]});
    foreach (ad[i]) rd(ad[i], ex[i]);
    wr(PBIO_ADDR_PWR, 8'h00);
    rd(PBIO_ADDR_PWR, 8'h1F);
    chk("pwr off", 2'b00, {watchdog_enable_o, low_voltage_detect_enable_o});
    wr(PBIO_ADDR_PWR, 8'h20);
    chk("pwr lvd", 2'b01, {watchdog_enable_o, low_voltage_detect_enable_o});
  endtask
  task automatic t_port();
    ext_en <= 8'h08;
    wr(PBIO_ADDR_PORT, 8'hA5);
    chk("latch", 8'hA5, pin_o);
    ld(0, 8'h00);
    // Reset leaves the external timer clock selected, so pin two stays an input
    chk("oe t2", 8'hF3, pin_oe_o);
    ld(1, 8'h00);
    pins(8'h08);
    chk("oe", 8'hF7, pin_oe_o);
    rd(PBIO_ADDR_PORT, 8'hAD);
    wr(PBIO_ADDR_ODR, 8'hFF);
    chk("od oe", 8'h52, pin_oe_o);
    rd(PBIO_ADDR_ODR, 8'hFF);
    wr(PBIO_ADDR_ODR, 8'h00);
    ld(0, 8'hFF);
    ext_en <= 8'hFF;
    pins(8'h3D);
    rd(PBIO_ADDR_PORT, 8'h3D);
    alt_func_i <= 8'h21;
    pins(8'h3D);
    rd(PBIO_ADDR_PORT, 8'h1C);
    alt_func_i <= 8'h00;
  endtask
  task automatic t_pull();
    wr(PBIO_ADDR_PDN, 8'h8F);
    wr(PBIO_ADDR_PUP, 8'h00);
    chk("pulls", {8'hF7, 2'b00}, {pull_up_o, 2'b00});
    chk("pdn", 8'h07, pull_down_o);
    rd(PBIO_ADDR_PDN, 8'h8F);
    ld(0, 8'hF0);
    chk("pu out", 8'hF0, pull_up_o);
    chk("pd out", 8'h00, pull_down_o);
    wr(PBIO_ADDR_PDN, 8'hFF);
    wr(PBIO_ADDR_PUP, 8'hFF);
  endtask
  task automatic t_cfg();
    ld(0, 8'h00);
    for (logic [3:0] n = 0; n < 8; n++) begin
      ld(1, {2'b00, 1'b1, n[0], ~n[0], n[2:0]});
      chk("rate", {n + 4'h1, n[2:0], n[0], ~n[0], 1'b0}, {timer_div_o[3:0], watchdog_div_o[2:0],
        timer_source_edge_o, prescaler_assign_o, pin_oe_o[2]});
    end
    ld(1, 8'h00);
    chk("tcs off", 2'b01, {timer_clock_source_o, pin_oe_o[2]});
    ld(0, 8'hFF);
  endtask
  task automatic t_irq();
    ovf();
    rd(PBIO_ADDR_IFLG, 8'h00);
    wr(PBIO_ADDR_IEN, 8'h01);
    rd(PBIO_ADDR_IFLG, 8'h01);
    wr(PBIO_ADDR_IEN, 8'h81);
    chk("take", 1'b1, irq_take_o);
    rd(PBIO_ADDR_IEN, 8'h79);
    wr(PBIO_ADDR_IFLG, 8'h00);
    @(posedge clk_i);
    return_from_irq_instr_i <= 1'b1;
    @(posedge clk_i);
    return_from_irq_instr_i <= 1'b0;
    rd(PBIO_ADDR_IEN, 8'hF9);
    sleeping_i <= 1'b1;
    ovf();
    chk("wake vec", {1'b1, PBIO_WAKE_VECTOR}, {wake_o, wake_kind_o});
    chk("vector", 10'h008, irq_vector_o);
    wr(PBIO_ADDR_IFLG, 8'h00);
    wr(PBIO_ADDR_IEN, 8'h01);
    ovf();
    chk("wake res", {1'b1, PBIO_WAKE_RESUME}, {wake_o, wake_kind_o});
    sleeping_i <= 1'b0;
    wr(PBIO_ADDR_IFLG, 8'h00);
  endtask
  task automatic t_ext();
    ld(0, 8'hFF);
    wr(PBIO_ADDR_IEN, 8'h04);
    wr(PBIO_ADDR_PWR, 8'h40);
    ld(1, 8'h40);
    pins(8'h00);
    wr(PBIO_ADDR_IFLG, 8'h00);
    pins(8'h01);
    rd(PBIO_ADDR_IFLG, 8'h04);
    wr(PBIO_ADDR_IFLG, 8'h00);
    pins(8'h00);
    rd(PBIO_ADDR_IFLG, 8'h00);
    ld(1, 8'h00);
    pins(8'h01);
    rd(PBIO_ADDR_IFLG, 8'h00);
    pins(8'h00);
    rd(PBIO_ADDR_IFLG, 8'h04);
    wr(PBIO_ADDR_PWR, 8'h00);
    wr(PBIO_ADDR_IFLG, 8'h00);
    pins(8'h01);
    pins(8'h00);
    rd(PBIO_ADDR_IFLG, 8'h00);
  endtask
  task automatic t_chg();
    wr(PBIO_ADDR_WAKE, 8'h03);
    wr(PBIO_ADDR_PWR, 8'h40);
    rd(PBIO_ADDR_PORT, 8'h00);
    wr(PBIO_ADDR_IEN, 8'h02);
    wr(PBIO_ADDR_IFLG, 8'h00);
    pins(8'h01);
    rd(PBIO_ADDR_IFLG, 8'h00);
    pins(8'h11);
    rd(PBIO_ADDR_IFLG, 8'h00);
    pins(8'h13);
    rd(PBIO_ADDR_IFLG, 8'h02);
  endtask
  // Reset in mid-run must bring back the power-up state
  task automatic t_rerst();
    ld(0, 8'h00);
    wr(PBIO_ADDR_IEN, 8'h87);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("rst oe", 8'h00, pin_oe_o);
    chk("rst latch", 8'h00, pin_o);
    chk("rst pwr", 2'b11, {watchdog_enable_o, low_voltage_detect_enable_o});
    rd(PBIO_ADDR_IEN, 8'h78);
    rd(PBIO_ADDR_IFLG, 8'h00);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Whole run needs about 270 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    {reg_wr_i, reg_rd_i, dir_load_i, cfg_load_i, return_from_irq_instr_i, timer_ovf_i, sleeping_i} = '0;
    {reg_addr_i, reg_wdata_i, acc_i, alt_func_i, ext_en, ext_v} = '0;
    sys_rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    t_reset();
    t_port();
    t_pull();
    t_cfg();
    t_irq();
    t_ext();
    t_chg();
    t_rerst();
    give_verdict();
  end
endmodule
